// file: logic/tcl_regs.svh
`ifndef TCL_REGS_SVH
`define TCL_REGS_SVH

// Termination setting codes
`define TCL_TERM_OFF      2'h0
`define TCL_TERM_QUARTER  2'h1
`define TCL_TERM_HALF     2'h2
// Latency and burst field widths
`define TCL_LAT_W         5
`define TCL_BURST_W       4
// Read command encoding on {ras_n, cas_n, we_n}
`define TCL_CMD_READ      3'h5
// Window counter width
`define TCL_CNT_W         6
// Strobe preamble length in half cycles
`define TCL_PREAMBLE_HALF 1

`endif

// file: logic/tcl_pkg.sv
package tcl_pkg;
  `include "tcl_regs.svh"

  // Command bus sample
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } tcl_cmd_type;

  // Mode settings
  typedef struct packed {
    logic [`TCL_LAT_W-1:0]   read_latency;
    logic [`TCL_BURST_W-1:0] burst_length;
    logic [1:0]              term_sel;
    logic                    dual_load;
    logic                    low_power_termination;
  } tcl_mode_type;

  // Termination enables per pin group
  typedef struct packed {
    logic addr;
    logic ctrl;
    logic cke;
    logic read_strobe;
    logic write_strobe;
    logic data;
    logic data_mask_lines;
  } tcl_term_type;

  // Window states
  typedef enum logic [2:0] {
    TCL_IDLE  = 3'b001,
    TCL_DELAY = 3'b010,
    TCL_OFF   = 3'b100
  } tcl_state_type;
endpackage

// file: logic/tcl_window.sv
`timescale 1ns/1ps
`include "tcl_regs.svh"
// Delay-then-hold window timer for one read
module tcl_window
  import tcl_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_start,
  input  wire logic [`TCL_CNT_W-1:0] i_delay,
  input  wire logic [`TCL_CNT_W-1:0] i_hold,
  output logic                       o_off
);
  tcl_state_type         state_reg;
  tcl_state_type         state_next;
  logic [`TCL_CNT_W-1:0] cnt_reg;
  logic [`TCL_CNT_W-1:0] cnt_next;
  wire                   delay_zero = (i_delay == '0);

  // New read restarts the window, cutting short any delay or switch-off already running
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (i_start) begin
      state_next = delay_zero ? TCL_OFF : TCL_DELAY;
      cnt_next   = delay_zero ? i_hold - 6'h01 : i_delay - 6'h01;
    end else begin
      unique case (state_reg)
        TCL_IDLE: ;
        TCL_DELAY: begin
          if (cnt_reg == '0) begin
            state_next = TCL_OFF;
            cnt_next   = i_hold - 6'h01;
          end else begin
            cnt_next = cnt_reg - 6'h01;
          end
        end
        TCL_OFF: begin
          if (cnt_reg == '0) begin
            state_next = TCL_IDLE;
          end else begin
            cnt_next = cnt_reg - 6'h01;
          end
        end
        default: state_next = TCL_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_reg <= TCL_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign o_off = (state_reg == TCL_OFF);
endmodule

// file: logic/tcl_top.sv
`timescale 1ns/1ps
`include "tcl_regs.svh"
// Overview of operation
// RL1: With dual-load data termination, any read on the bus switches data termination off.
// RL2: Switch-off starts read_latency-1 clocks after the read and lasts burst_length+2 clocks.
// RL3: Reads to either rank are snooped, so both ranks drop data termination.
// RL4: Outside low-power mode, address, command and clock-enable pins stay terminated regardless of snooping.
// RL5: A single mode bit turns low-power termination off (0) or on (1).
// RL6: Low-power mode takes effect only with the quarter or half reference setting.
// RL7: Low-power mode turns off address, command strobes, chip select and clock-enable termination.
// RL8: Low-power mode keeps write strobes programmed, and disables read strobe, data and mask.
// RL9: Without low-power mode, strobes, data and mask use the programmed impedance.
// RL10: The controller lowers the clock rate while low-power mode is in use; the bench controller model and clock keep one fixed rate.
// RL11: The read strobe is driven high half a cycle before its first falling edge; the preamble is only produced when read_latency is 2.
// RL12: Data termination offers exactly quarter and half of the reference resistor.
// RL13: Latency and burst come live from the mode settings, following reprogramming.
module tcl_top
  import tcl_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  // Command bus pins
  input  wire logic        I_CS_N,
  input  wire logic        I_RAS_N,
  input  wire logic        I_CAS_N,
  input  wire logic        I_WE_N,
  // Mode settings
  input  wire logic [4:0]  I_READ_LATENCY,
  input  wire logic [3:0]  I_BURST_LENGTH,
  input  wire logic [1:0]  I_TERM_SEL,
  input  wire logic        I_DUAL_LOAD,
  input  wire logic        I_LOW_POWER_TERMINATION,
  // Termination enables
  output logic             O_TERM_ADDR,
  output logic             O_TERM_CTRL,
  output logic             O_TERM_CKE,
  output logic             O_TERM_READ_STROBE,
  output logic             O_TERM_WRITE_STROBE,
  output logic             O_TERM_DATA,
  output logic             O_TERM_DATA_MASK_LINES,
  output logic [1:0]       O_TERM_IMPEDANCE,
  // Read strobe preamble
  output logic             O_READ_STROBE_PREAMBLE
);
  tcl_cmd_type  cmd_meta_reg;
  tcl_cmd_type  cmd_sync_reg;
  tcl_mode_type mode_meta_reg;
  tcl_mode_type mode_sync_reg;
  tcl_term_type term_reg;
  tcl_term_type term_next;
  logic [1:0]   imp_reg;
  logic         pre_reg;

  // Pins cross in through two flops; the first one feeds only the second
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      cmd_meta_reg  <= 4'hf;
      cmd_sync_reg  <= 4'hf;
      mode_meta_reg <= '0;
      mode_sync_reg <= '0;
    end else begin
      cmd_meta_reg  <= '{I_CS_N, I_RAS_N, I_CAS_N, I_WE_N};
      cmd_sync_reg  <= cmd_meta_reg;
      mode_meta_reg <= '{I_READ_LATENCY, I_BURST_LENGTH, I_TERM_SEL, I_DUAL_LOAD,
                         I_LOW_POWER_TERMINATION};
      mode_sync_reg <= mode_meta_reg;
    end
  end

  // Read decode ignores chip select so both ranks see every read
  wire is_read = ({cmd_sync_reg.ras_n, cmd_sync_reg.cas_n, cmd_sync_reg.we_n}
                  == `TCL_CMD_READ); // RL1 RL3

  // Only quarter and half settings are legal impedances
  wire term_legal = (mode_sync_reg.term_sel == `TCL_TERM_QUARTER) ||
                    (mode_sync_reg.term_sel == `TCL_TERM_HALF); // RL12

  // Low-power mode is refused with any other setting
  wire lpt_on = mode_sync_reg.low_power_termination & term_legal; // RL5 RL6

  // Window limits from live mode settings; latency 0 treated as no delay
  wire [5:0] win_delay = (mode_sync_reg.read_latency == 5'h00) ? 6'h00 :
                         {1'b0, mode_sync_reg.read_latency} - 6'h01; // RL2 RL13
  wire [5:0] win_hold  = {2'b00, mode_sync_reg.burst_length} + 6'h02; // RL2 RL13
  wire       snoop     = is_read & mode_sync_reg.dual_load; // RL1
  wire       win_off;

  tcl_window u_window (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_start (snoop),
    .i_delay (win_delay),
    .i_hold  (win_hold),
    .o_off   (win_off)
  );

  // Preamble: strobe driven one cycle ahead of data window, giving a half-cycle
  // high level before the first falling edge at the pad
  wire snoop_pre = is_read & (mode_sync_reg.read_latency == 5'h02); // RL11

  // Pin group enables; non-data pins ignore snooping
  wire dq_on = term_legal & ~lpt_on & ~win_off; // RL8 RL9
  always_comb begin
    term_next.addr            = ~lpt_on; // RL4 RL7
    term_next.ctrl            = ~lpt_on; // RL7
    term_next.cke             = ~lpt_on; // RL7
    term_next.read_strobe     = term_legal & ~lpt_on; // RL8 RL9
    term_next.write_strobe    = term_legal; // RL8
    term_next.data            = dq_on; // RL1
    term_next.data_mask_lines = dq_on; // RL8
  end

  // Registered outputs; enables come up on after reset for safety
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      term_reg <= 7'h7f;
      imp_reg  <= `TCL_TERM_OFF;
      pre_reg  <= 1'b0;
    end else begin
      term_reg <= term_next;
      imp_reg  <= term_legal ? mode_sync_reg.term_sel : `TCL_TERM_OFF; // RL9
      pre_reg  <= snoop_pre; // RL11
    end
  end

  assign O_TERM_ADDR            = term_reg.addr;
  assign O_TERM_CTRL            = term_reg.ctrl;
  assign O_TERM_CKE             = term_reg.cke;
  assign O_TERM_READ_STROBE     = term_reg.read_strobe;
  assign O_TERM_WRITE_STROBE    = term_reg.write_strobe;
  assign O_TERM_DATA            = term_reg.data;
  assign O_TERM_DATA_MASK_LINES = term_reg.data_mask_lines;
  assign O_TERM_IMPEDANCE       = imp_reg;
  assign O_READ_STROBE_PREAMBLE = pre_reg;
endmodule

// file: bench/tcl_top_chk.sv
`timescale 1ns/1ps
`include "tcl_regs.svh"
// Watches mode-driven termination levels at the top ports
module tcl_top_chk
  import tcl_pkg::*;
(
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RST_B,
  // Mode settings
  input  wire logic [1:0] I_TERM_SEL,
  input  wire logic       I_LOW_POWER_TERMINATION,
  // Termination enables
  input  wire logic       O_TERM_ADDR,
  input  wire logic       O_TERM_CTRL,
  input  wire logic       O_TERM_CKE,
  input  wire logic       O_TERM_READ_STROBE,
  input  wire logic       O_TERM_WRITE_STROBE,
  input  wire logic       O_TERM_DATA,
  input  wire logic       O_TERM_DATA_MASK_LINES,
  input  wire logic [1:0] O_TERM_IMPEDANCE
);
  logic [8:0] pipe_reg;
  logic [2:0] up_reg;
  // Mode as sampled three edges back, matching sync plus output stage
  wire  [1:0] sel3  = pipe_reg[7:6];
  wire        legal = (sel3 == `TCL_TERM_QUARTER) || (sel3 == `TCL_TERM_HALF);
  wire        lpe   = pipe_reg[8] & legal;
  wire        up    = (up_reg == 3'h5);
  // Pipeline is not reset, so checks wait until it has refilled
  always_ff @(posedge I_CLK) begin
    pipe_reg <= {pipe_reg[5:0], I_LOW_POWER_TERMINATION, I_TERM_SEL};
    up_reg   <= !I_RST_B ? 3'h0 : up_reg + {2'h0, !up};
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  property p_addr; up |-> O_TERM_ADDR == !lpe; endproperty
  a_addr: assert property (p_addr) else $error("address termination wrong");
  property p_ctrl; up |-> O_TERM_CTRL == !lpe; endproperty
  a_ctrl: assert property (p_ctrl) else $error("command termination wrong");
  property p_cke; up |-> O_TERM_CKE == !lpe; endproperty
  a_cke: assert property (p_cke) else $error("clock enable termination wrong");
  property p_ws; up |-> O_TERM_WRITE_STROBE == legal; endproperty
  a_ws: assert property (p_ws) else $error("write strobe termination wrong");
  property p_rs; up |-> O_TERM_READ_STROBE == (legal && !lpe); endproperty
  a_rs: assert property (p_rs) else $error("read strobe termination wrong");
  property p_data; up && (lpe || !legal) |-> !O_TERM_DATA; endproperty
  a_data: assert property (p_data) else $error("data termination wrong");
  property p_mask; up |-> O_TERM_DATA_MASK_LINES == O_TERM_DATA; endproperty
  a_mask: assert property (p_mask) else $error("mask termination wrong");
  property p_imp; up |-> O_TERM_IMPEDANCE == (legal ? sel3 : 2'h0); endproperty
  a_imp: assert property (p_imp) else $error("impedance code wrong");
endmodule
bind tcl_top tcl_top_chk tcl_top_chk_i (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
  .I_TERM_SEL(I_TERM_SEL), .I_LOW_POWER_TERMINATION(I_LOW_POWER_TERMINATION),
  .O_TERM_ADDR(O_TERM_ADDR), .O_TERM_CTRL(O_TERM_CTRL), .O_TERM_CKE(O_TERM_CKE),
  .O_TERM_READ_STROBE(O_TERM_READ_STROBE), .O_TERM_WRITE_STROBE(O_TERM_WRITE_STROBE),
  .O_TERM_DATA(O_TERM_DATA), .O_TERM_DATA_MASK_LINES(O_TERM_DATA_MASK_LINES),
  .O_TERM_IMPEDANCE(O_TERM_IMPEDANCE));

// file: bench/tcl_ctrl_model.sv
`timescale 1ns/1ps
`include "tcl_regs.svh"
// Controller side of the command bus
module tcl_ctrl_model
  import tcl_pkg::*;
(
  // Request from bench
  input  wire logic  i_read,
  input  wire logic  i_cs_n,
  // Command pins
  output tcl_cmd_type o_cmd
);
  // Read to either rank, otherwise an all-high no-op
  assign o_cmd = i_read ? {i_cs_n, `TCL_CMD_READ} : 4'hf;
endmodule

// file: bench/tcl_top_tb_top.sv
`timescale 1ns/1ps
module tcl_top_tb_top;
  import tcl_pkg::*;
  logic clk = 0, rst_b = 0, rd = 0, cs_n = 1, dual = 1, lp = 0, lg, pre;
  logic [4:0] lat = 5'h2;
  logic [3:0] bl = 4'h4;
  logic [1:0] sel = 2'h2, imp;
  logic [7:0] lfsr = 8'h42;
  int mismatches = 0, total_checks = 0;
  tcl_cmd_type cmd;
  tcl_term_type t;
  tcl_ctrl_model tcl_ctrl_model_i (.i_read(rd), .i_cs_n(cs_n), .o_cmd(cmd));
  tcl_top tcl_top_i (.I_CLK(clk), .I_RST_B(rst_b), .I_CS_N(cmd.cs_n), .I_RAS_N(cmd.ras_n),
    .I_CAS_N(cmd.cas_n), .I_WE_N(cmd.we_n), .I_READ_LATENCY(lat), .I_BURST_LENGTH(bl),
    .I_TERM_SEL(sel), .I_DUAL_LOAD(dual), .I_LOW_POWER_TERMINATION(lp),
    .O_TERM_ADDR(t.addr), .O_TERM_CTRL(t.ctrl), .O_TERM_CKE(t.cke),
    .O_TERM_READ_STROBE(t.read_strobe), .O_TERM_WRITE_STROBE(t.write_strobe),
    .O_TERM_DATA(t.data), .O_TERM_DATA_MASK_LINES(t.data_mask_lines),
    .O_TERM_IMPEDANCE(imp), .O_READ_STROBE_PREAMBLE(pre));
  initial forever #4 clk = ~clk;
  // Random source, fixed start for repeatable runs
  function automatic logic [7:0] nxt(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Delay and length of the switch-off window both carry two extra clocks
  function automatic int exp_span(int base);
    return base + 2;
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One read, then time the data termination dip
  task automatic do_read();
    int n = 0;
    int w = 0;
    int pn = 0;
    @(posedge clk) rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (pre === 1'b1) pn = n;
    end while (t.data === 1'b1 && n < 40);
    // Preamble pulse lands three edges after the pin read when latency is two
    chk("preamble", (lat == 5'h02) ? 8'h02 : 8'h00, 8'(pn));
    while (t.data === 1'b0 && w < 40) begin @(posedge clk); #1; w++; end
    if (dual) begin
      chk("delay", 8'(exp_span(int'(lat))), 8'(n));
      chk("length", 8'(exp_span(int'(bl))), 8'(w));
    end else chk("no_dip", 8'h28, 8'(n));
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    do_read();
    // Random latency, burst and rank; settings re-synced before each read
    repeat (6) begin
      @(posedge clk);
      lfsr = nxt(lfsr);
      lat <= 5'(lfsr[2:0]) + 5'h1;
      bl <= lfsr[6:3];
      cs_n <= lfsr[7];
      repeat (4) @(posedge clk);
      do_read();
    end
    @(posedge clk) dual <= 1'b0;
    repeat (4) @(posedge clk);
    do_read();
    // Every setting code, the illegal one too; low-power bit off and on for quarter and half only
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        @(posedge clk) sel <= 2'(s);
        lp <= p[0] & ((s == 1) || (s == 2));
        repeat (5) @(posedge clk);
        #1;
        lg = (s == 1) || (s == 2);
        chk("term", {1'b0, ~lp, ~lp, ~lp, lg & ~lp, lg, lg & ~lp, lg & ~lp}, {1'b0, t});
        chk("imp", lg ? 8'(s) : 8'h00, {6'h0, imp});
      end
    end
    // Mid-run reset: every enable up, no impedance, then a clean read again
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("reset_term", 8'h7f, {1'b0, t});
    chk("reset_imp", 8'h00, {6'h0, imp});
    @(posedge clk) rst_b <= 1'b1;
    dual <= 1'b1;
    sel <= 2'h2;
    repeat (4) @(posedge clk);
    do_read();
    test_done();
  end
  // Hang guard, well beyond the expected few hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule
